// File: hdl/general_purpose_timer.sv
// General-purpose timer with AHB-Lite register access, ADC and DMA triggers
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "gpt_cfg.svh"

module general_purpose_timer (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic                   edgePin,
  output gpt_pkg::timer_events_s      events
);

  logic [`GPT_CTRL_W-1:0]       ctrlFf;
  gpt_pkg::timer_mode_config_s  modeFf;
  logic [31:0]                  loadFf;
  logic [31:0]                  matchFf;
  logic [7:0]                   prescaleLoadFf;
  logic [`GPT_IMASK_W-1:0]      imaskFf;
  logic [31:0]                  cntFf;
  logic [7:0]                   pscFf;
  logic [31:0]                  snapFf;
  logic [31:0]                  hrdataFf;
  logic [7:0]                   addrFf;
  logic                         wrFf;
  logic [2:0]                   syncFf;
  logic                         lvlFf;
  gpt_pkg::timer_events_s       eventsFf;

  logic                         addrPhase;
  logic                         edgeRise;
  logic                         runEn;
  logic                         adcOte;
  logic                         tick;
  logic                         toEvt;
  logic                         matchEq;
  logic                         snapTake;
  logic                         valWrite;
  logic [31:0]                  top;
  logic [31:0]                  nxt_cnt;
  logic [7:0]                   nxt_psc;
  logic [23:0]                  ext24;
  logic [31:0]                  countView;
  logic [31:0]                  rdMux;

  assign runEn     = ctrlFf[`GPT_CTRL_EN];
  assign adcOte    = ctrlFf[`GPT_CTRL_OTE];
  assign addrPhase = hsel && htrans[1] && hready;
  assign valWrite  = wrFf && (addrFf == `GPT_OFS_VALUE);
  assign top       = modeFf.split16 ? {16'h0000, loadFf[15:0]} : loadFf;
  assign ext24     = {pscFf, cntFf[15:0]};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdataFf;
  assign events    = eventsFf;

  // Match compare runs whether or not the timer is enabled
  assign matchEq = modeFf.split16 ? (cntFf[15:0] == matchFf[15:0]) : (cntFf == matchFf);

  // AHB-Lite: zero wait states, read data registered at the address phase
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      addrFf <= 8'h00;
      wrFf   <= 1'b0;
    end
    else
    begin
      addrFf <= haddr[7:0];
      wrFf   <= addrPhase && hwrite;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      hrdataFf <= 32'h00000000;
    else if (addrPhase && !hwrite)
      hrdataFf <= rdMux;
  end

  // Edge-count mode shows the prescale load, not the live extension
  always_comb
  begin
    if (modeFf.mode == gpt_pkg::MODE_EDGE_COUNT)
      countView = {8'h00, prescaleLoadFf, cntFf[15:0]};
    else if (modeFf.split16)
      countView = {16'h0000, cntFf[15:0]};
    else
      countView = cntFf;
  end

  always_comb
  begin
    unique case (haddr[7:0])
      `GPT_OFS_CTRL:     rdMux = {30'h00000000, ctrlFf};
      `GPT_OFS_MODE:     rdMux = {23'h000000, modeFf};
      `GPT_OFS_LOAD:     rdMux = loadFf;
      `GPT_OFS_MATCH:    rdMux = matchFf;
      `GPT_OFS_PRESCALE: rdMux = {24'h000000, prescaleLoadFf};
      `GPT_OFS_IMASK:    rdMux = {30'h00000000, imaskFf};
      `GPT_OFS_VALUE:    rdMux = countView;
      `GPT_OFS_COUNT:    rdMux = countView;
      `GPT_OFS_ACOUNT:   rdMux = (modeFf.halfASnapshotEnable || modeFf.halfBSnapshotEnable) ? snapFf : countView;
      default:           rdMux = 32'h00000000;
    endcase
  end

  // Software registers; a one-shot timeout clears the enable unless software writes it
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrlFf         <= `GPT_RST_CTRL;
      modeFf         <= gpt_pkg::timer_mode_config_s'(`GPT_RST_MODE);
      loadFf         <= `GPT_RST_LOAD;
      matchFf        <= `GPT_RST_MATCH;
      prescaleLoadFf <= `GPT_RST_PRESCALE;
      imaskFf        <= `GPT_RST_IMASK;
    end
    else
    begin
      if (toEvt && modeFf.mode == gpt_pkg::MODE_ONE_SHOT)
        ctrlFf[`GPT_CTRL_EN] <= 1'b0;
      if (wrFf)
      begin
        unique case (addrFf)
          `GPT_OFS_CTRL:     ctrlFf <= hwdata[`GPT_CTRL_W-1:0];
          `GPT_OFS_MODE:     modeFf <= gpt_pkg::timer_mode_config_s'(hwdata[`GPT_MODE_W-1:0]);
          `GPT_OFS_LOAD:     loadFf <= hwdata;
          `GPT_OFS_MATCH:    matchFf <= hwdata;
          `GPT_OFS_PRESCALE: prescaleLoadFf <= hwdata[7:0];
          `GPT_OFS_IMASK:    imaskFf <= hwdata[`GPT_IMASK_W-1:0];
          default:           ;
        endcase
      end
    end
  end

  // Edge pin: three flops, a level counts once the last two agree
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      syncFf <= 3'h0;
      lvlFf  <= 1'b0;
    end
    else
    begin
      syncFf <= {syncFf[1:0], edgePin};
      if (syncFf[1] == syncFf[2])
        lvlFf <= syncFf[2];
    end
  end

  assign edgeRise = syncFf[1] && syncFf[2] && !lvlFf;

  // Counter next state
  always_comb
  begin
    tick    = 1'b0;
    toEvt   = 1'b0;
    nxt_cnt = cntFf;
    nxt_psc = pscFf;
    if (runEn)
    begin
      unique case (modeFf.mode)
        gpt_pkg::MODE_EDGE_COUNT:
        begin
          if (edgeRise)
          begin
            tick = 1'b1;
            if (ext24 == 24'h000000)
            begin
              {nxt_psc, nxt_cnt[15:0]} = {prescaleLoadFf, loadFf[15:0]};
              toEvt = 1'b1;
            end
            else
              {nxt_psc, nxt_cnt[15:0]} = ext24 - 24'h000001;
          end
        end
        gpt_pkg::MODE_ONE_SHOT, gpt_pkg::MODE_PERIODIC:
        begin
          // Prescaler is bypassed counting up; it is unreliable there anyway
          if (modeFf.countUp)
            tick = 1'b1;
          else if (pscFf == 8'h00)
          begin
            tick    = 1'b1;
            nxt_psc = prescaleLoadFf;
          end
          else
            nxt_psc = pscFf - 8'h01;
          if (tick && modeFf.countUp)
          begin
            if (cntFf == top)
            begin
              nxt_cnt = 32'h00000000;
              toEvt   = 1'b1;
            end
            else
              nxt_cnt = cntFf + 32'h00000001;
          end
          else if (tick)
          begin
            if ((modeFf.split16 ? cntFf[15:0] == 16'h0000 : cntFf == 32'h00000000))
            begin
              nxt_cnt = top;
              toEvt   = 1'b1;
            end
            else
              nxt_cnt = cntFf - 32'h00000001;
          end
        end
        gpt_pkg::MODE_UNUSED: ;
      endcase
    end
    if (valWrite && !modeFf.countUp)
      nxt_cnt = modeFf.split16 ? {16'h0000, hwdata[15:0]} : hwdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cntFf <= `GPT_RST_COUNT;
      pscFf <= `GPT_RST_PRESCALE;
    end
    else
    begin
      cntFf <= nxt_cnt;
      pscFf <= nxt_psc;
    end
  end

  // Snapshot: with a single half enabled only the low half is kept
  assign snapTake = toEvt && modeFf.mode == gpt_pkg::MODE_PERIODIC && !modeFf.split16
                    && (modeFf.halfASnapshotEnable || modeFf.halfBSnapshotEnable);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      snapFf <= 32'h00000000;
    else if (snapTake)
    begin
      if (modeFf.halfASnapshotEnable && modeFf.halfBSnapshotEnable)
        snapFf <= cntFf;
      else
        snapFf <= {16'h0000, cntFf[15:0]};
    end
  end

  // Triggers and events; PWM mode deliberately does not suppress them
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      eventsFf <= '0;
    else
    begin
      eventsFf.adcTrig       <= adcOte && matchEq;
      eventsFf.waitTrig      <= modeFf.waitOnTriggerSelect && adcOte && matchEq;
      eventsFf.matchDmaReq   <= tick && matchEq;
      eventsFf.timeoutDmaReq <= toEvt;
      eventsFf.matchIrq      <= tick && matchEq && modeFf.matchIntEn && imaskFf[`GPT_IMASK_MATCH];
      eventsFf.timeoutIrq    <= toEvt && imaskFf[`GPT_IMASK_TMO];
      eventsFf.pwmOut        <= modeFf.pwm && (cntFf[15:0] > matchFf[15:0]);
    end
  end

  chk_adc_trig_disabled: assert property (@(posedge clk_sys) disable iff (srst)
    (adcOte && matchEq) |=> events.adcTrig)
    else $error("ADC trigger missed on match");

  chk_wot_fires: assert property (@(posedge clk_sys) disable iff (srst)
    (modeFf.waitOnTriggerSelect && adcOte && matchEq && !runEn) |=> events.waitTrig)
    else $error("Chained trigger missed while disabled");

  chk_wot_needs_ote: assert property (@(posedge clk_sys) disable iff (srst)
    events.waitTrig |-> $past(adcOte) && events.adcTrig)
    else $error("Chained trigger without ADC trigger enable");

  chk_pwm_timeout_irq: assert property (@(posedge clk_sys) disable iff (srst)
    (modeFf.pwm && toEvt && imaskFf[`GPT_IMASK_TMO]) |=> events.timeoutIrq)
    else $error("PWM timeout event suppressed");

  chk_pwm_dma_req: assert property (@(posedge clk_sys) disable iff (srst)
    (modeFf.pwm && tick && matchEq) |=> events.matchDmaReq)
    else $error("PWM match DMA request suppressed");

  chk_up_write_ignored: assert property (@(posedge clk_sys) disable iff (srst)
    (valWrite && modeFf.countUp && !tick) |=> cntFf == $past(cntFf))
    else $error("Value write changed count while counting up");

  chk_edge_readback: assert property (@(posedge clk_sys) disable iff (srst)
    (modeFf.mode == gpt_pkg::MODE_EDGE_COUNT) |-> countView[23:16] == prescaleLoadFf)
    else $error("Edge-count readback upper byte wrong");

  chk_edge_borrow: assert property (@(posedge clk_sys) disable iff (srst)
    (modeFf.mode == gpt_pkg::MODE_EDGE_COUNT && runEn && edgeRise && cntFf[15:0] == 16'h0000
     && pscFf != 8'h00 && !valWrite && !wrFf)
    |=> pscFf == $past(pscFf) - 8'h01 && cntFf[15:0] == 16'hffff)
    else $error("Edge-count extension did not borrow");

  chk_snap_half: assert property (@(posedge clk_sys) disable iff (srst)
    (snapTake && (modeFf.halfASnapshotEnable != modeFf.halfBSnapshotEnable))
    |=> snapFf == {16'h0000, $past(cntFf[15:0])})
    else $error("Single-half snapshot stored upper bits");

  chk_snap_full: assert property (@(posedge clk_sys) disable iff (srst)
    (snapTake && modeFf.halfASnapshotEnable && modeFf.halfBSnapshotEnable) |=> snapFf == $past(cntFf))
    else $error("Full snapshot not stored");

endmodule // general_purpose_timer

// File: hdl/gpt_cfg.svh
// Register offsets, field positions, reset values for the general-purpose timer
`ifndef GPT_CFG_SVH
`define GPT_CFG_SVH

`define GPT_OFS_CTRL      8'h00
`define GPT_OFS_MODE      8'h04
`define GPT_OFS_LOAD      8'h08
`define GPT_OFS_MATCH     8'h0c
`define GPT_OFS_PRESCALE  8'h10
`define GPT_OFS_IMASK     8'h14
`define GPT_OFS_VALUE     8'h18
`define GPT_OFS_COUNT     8'h1c
`define GPT_OFS_ACOUNT    8'h20

`define GPT_CTRL_EN       0
`define GPT_CTRL_OTE      1
`define GPT_CTRL_W        2
`define GPT_MODE_W        9
`define GPT_IMASK_TMO     0
`define GPT_IMASK_MATCH   1
`define GPT_IMASK_W       2

`define GPT_RST_CTRL      2'h0
`define GPT_RST_MODE      9'h000
`define GPT_RST_LOAD      32'hffffffff
`define GPT_RST_MATCH     32'hffffffff
`define GPT_RST_PRESCALE  8'h00
`define GPT_RST_IMASK     2'h0
`define GPT_RST_COUNT     32'hffffffff

`endif

// File: hdl/gpt_pkg.sv
// Types shared by the general-purpose timer
package gpt_pkg;

  typedef enum logic [1:0] {
    MODE_ONE_SHOT,
    MODE_PERIODIC,
    MODE_EDGE_COUNT,
    MODE_UNUSED
  } timer_mode_e;

  // timer_mode_config layout, bit 8 down to bit 0
  typedef struct packed {
    logic        split16;
    logic        matchIntEn;
    logic        halfBSnapshotEnable;
    logic        halfASnapshotEnable;
    logic        waitOnTriggerSelect;
    logic        pwm;
    logic        countUp;
    timer_mode_e mode;
  } timer_mode_config_s;

  typedef struct packed {
    logic adcTrig;
    logic waitTrig;
    logic matchDmaReq;
    logic timeoutDmaReq;
    logic matchIrq;
    logic timeoutIrq;
    logic pwmOut;
  } timer_events_s;

endpackage

// File: bench/trig_dma_sink.sv
// Model of the ADC trigger input and the DMA request logic that follow the timer
`timescale 1ns/10ps
module trig_dma_sink (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire logic                   clr,
  input  wire gpt_pkg::timer_events_s events,
  output logic      [7:0]             adcCnt,
  output logic      [7:0]             mDma,
  output logic      [7:0]             tDma,
  output logic      [7:0]             mIrq,
  output logic      [7:0]             tIrq
);
  logic adcLast;

  // DMA and interrupt requests are taken every cycle they are offered, the ADC trigger once per rising edge; the DMA side never stalls
  always_ff @(posedge clk_sys)
  begin
    adcLast <= events.adcTrig;
    if (srst || clr)
    begin
      adcCnt <= 8'h00;
      mDma   <= 8'h00;
      tDma   <= 8'h00;
      mIrq   <= 8'h00;
      tIrq   <= 8'h00;
    end
    else
    begin
      adcCnt <= adcCnt + 8'(events.adcTrig && !adcLast);
      mDma   <= mDma + 8'(events.matchDmaReq);
      tDma   <= tDma + 8'(events.timeoutDmaReq);
      mIrq   <= mIrq + 8'(events.matchIrq);
      tIrq   <= tIrq + 8'(events.timeoutIrq);
    end
  end
endmodule // trig_dma_sink

// File: bench/tb_top.sv
// Self-checking bench for the general-purpose timer
`timescale 1ns/10ps
`include "gpt_cfg.svh"
module tb_top;
  logic                   clk_sys = 1'b0;
  logic                   srst = 1'b1;
  logic                   hsel = 1'b0;
  logic [31:0]            haddr = 32'h0;
  logic [1:0]             htrans = 2'h0;
  logic                   hwrite = 1'b0;
  logic [2:0]             hsize = 3'h2;
  logic [31:0]            hwdata = 32'h0;
  logic [31:0]            hrdata;
  logic                   hreadyout;
  logic                   hresp;
  logic                   edgePin = 1'b0;
  logic                   clr = 1'b0;
  gpt_pkg::timer_events_s events;
  logic [7:0]             adcCnt;
  logic [7:0]             mDma;
  logic [7:0]             tDma;
  logic [7:0]             mIrq;
  logic [7:0]             tIrq;
  int                     errors = 0;
  int                     checkCount = 0;
  int                     cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  general_purpose_timer u_dut (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .edgePin(edgePin), .events(events));

  trig_dma_sink u_sink (.clk_sys(clk_sys), .srst(srst), .clr(clr), .events(events), .adcCnt(adcCnt),
    .mDma(mDma), .tDma(tDma), .mIrq(mIrq), .tIrq(tIrq));

  task automatic end_of_test();
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic isWr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= isWr;
    haddr  <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
    chk("bus response", 32'h0, 32'(hresp));
  endtask

  task automatic run(input int n);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    wr(`GPT_OFS_CTRL, 32'h1);
    repeat (n) @(posedge clk_sys);
    wr(`GPT_OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic edges(input int n);
    repeat (n)
    begin
      edgePin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      edgePin <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic t_trig_disabled();
    wr(`GPT_OFS_CTRL, 32'h2);
    repeat (3) @(posedge clk_sys);
    chk("adc trig off-run", 32'h1, 32'(events.adcTrig));
    chk("chain trig no select", 32'h0, 32'(events.waitTrig));
    wr(`GPT_OFS_MODE, 32'h10);
    repeat (3) @(posedge clk_sys);
    chk("chain trig off-run", 32'h1, 32'(events.waitTrig));
    wr(`GPT_OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk("chain trig no adc enable", 32'h0, 32'(events.waitTrig));
    chk("adc trig cleared", 32'h0, 32'(events.adcTrig));
    chk("adc trigger edges", 32'h1, 32'(adcCnt));
    wr(`GPT_OFS_MODE, 32'h0);
  endtask

  task automatic t_value_up();
    wr(`GPT_OFS_MODE, 32'h5);
    wr(`GPT_OFS_VALUE, 32'h1234);
    rdchk("count after up write", `GPT_OFS_COUNT, 32'hffffffff);
    wr(`GPT_OFS_MODE, 32'h1);
    wr(`GPT_OFS_VALUE, 32'h1234);
    rdchk("count after down write", `GPT_OFS_COUNT, 32'h1234);
    // One-shot: the timeout drops the run enable by itself
    wr(`GPT_OFS_MODE, 32'h0);
    wr(`GPT_OFS_VALUE, 32'h3);
    wr(`GPT_OFS_CTRL, 32'h1);
    repeat (10) @(posedge clk_sys);
    rdchk("one-shot enable", `GPT_OFS_CTRL, 32'h0);
  endtask

  task automatic t_edge_count();
    wr(`GPT_OFS_MODE, 32'h2);
    wr(`GPT_OFS_LOAD, 32'h0);
    wr(`GPT_OFS_PRESCALE, 32'h5a);
    wr(`GPT_OFS_VALUE, 32'h3);
    rdchk("edge readback", `GPT_OFS_COUNT, 32'h005a0003);
    wr(`GPT_OFS_CTRL, 32'h1);
    edges(2);
    rdchk("edge readback counted", `GPT_OFS_COUNT, 32'h005a0001);
    // Down to zero, reload from the prescale load, then borrow from the live extension
    edges(3);
    rdchk("edge readback borrow", `GPT_OFS_COUNT, 32'h005affff);
    wr(`GPT_OFS_CTRL, 32'h0);
    wr(`GPT_OFS_PRESCALE, 32'h0);
    // Mid-run reset clears the live extension left behind by edge counting
    srst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    rdchk("count after reset", `GPT_OFS_COUNT, 32'hffffffff);
  endtask

  task automatic t_pwm();
    wr(`GPT_OFS_MODE, 32'h189);
    wr(`GPT_OFS_LOAD, 32'h8);
    wr(`GPT_OFS_MATCH, 32'h4);
    wr(`GPT_OFS_VALUE, 32'h8);
    wr(`GPT_OFS_IMASK, 32'h3);
    chk("pwm level", 32'h1, 32'(events.pwmOut));
    run(40);
    chk("pwm match irq", 32'h1, 32'(mIrq != 8'h00));
    chk("pwm timeout irq", 32'h1, 32'(tIrq != 8'h00));
    wr(`GPT_OFS_IMASK, 32'h0);
    run(40);
    chk("masked match irq", 32'h0, 32'(mIrq));
    chk("masked timeout irq", 32'h0, 32'(tIrq));
    chk("pwm match dma", 32'h1, 32'(mDma != 8'h00));
    chk("pwm timeout dma", 32'h1, 32'(tDma != 8'h00));
    // Timer running first, then the trigger enable, so nothing fires while stopped
    wr(`GPT_OFS_CTRL, 32'h1);
    wr(`GPT_OFS_CTRL, 32'h3);
    repeat (20) @(posedge clk_sys);
    wr(`GPT_OFS_CTRL, 32'h0);
    chk("adc trig running", 32'h1, 32'(adcCnt != 8'h00));
  endtask

  // Prescaler stays at zero while counting up, since prescaled up-counting is unreliable
  task automatic snap(input logic [31:0] mode, input logic [31:0] exp);
    wr(`GPT_OFS_MODE, 32'h1);
    wr(`GPT_OFS_LOAD, 32'h00020005);
    wr(`GPT_OFS_VALUE, 32'h00020003);
    wr(`GPT_OFS_MODE, mode);
    run(12);
    rdchk("snapshot", `GPT_OFS_ACOUNT, exp);
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    t_trig_disabled();
    t_value_up();
    t_edge_count();
    t_pwm();
    snap(32'h25, 32'h00000005);
    snap(32'h65, 32'h00020005);
    end_of_test();
  end
endmodule // tb_top
